// [shared/sdpdt_pkg.sv]
// Package for the DDR3 power-down and termination control block.
// Assumes one command clock; commands arrive already decoded by the core.
package sdpdt_pkg;

  // ------------------------------------------------------------
  // Command encodings
  // ------------------------------------------------------------
  localparam logic [3:0] SDPDT_CMD_DESELECT = 4'hF;
  localparam logic [3:0] SDPDT_CMD_NOP = 4'h7;

  // ------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------
  localparam int SDPDT_RTT_A2 = 2;
  localparam int SDPDT_RTT_A6 = 6;
  localparam int SDPDT_RTT_A9 = 9;
  localparam int SDPDT_TDQS_A11 = 11;
  localparam int SDPDT_DLL_A12 = 12;
  localparam int SDPDT_LAT_W = 5;
  localparam int SDPDT_PIPE_D = 32;
  localparam logic [SDPDT_LAT_W-1:0] SDPDT_ODT_OFFSET = 5'h02;

  // ------------------------------------------------------------
  // Timing constants
  // ------------------------------------------------------------
  localparam int SDPDT_CLK_MHZ = 100;
  localparam int SDPDT_TXPDLL_NS = 240;
  localparam logic [7:0] SDPDT_TXPDLL_CYC =
    8'((SDPDT_TXPDLL_NS * SDPDT_CLK_MHZ + 999) / 1000);

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SDPDT_ACTIVE = 2'b00,
    SDPDT_PDOWN = 2'b01,
    SDPDT_SREF = 2'b10,
    SDPDT_RELOCK = 2'b11
  } sdpdt_state_t;

  typedef struct packed
  {
    logic [15:0] mr1;
    logic [15:0] mr0;
    logic [SDPDT_LAT_W-1:0] cwl;
    logic [SDPDT_LAT_W-1:0] al;
  } sdpdt_cfg_t;

  typedef struct packed
  {
    logic odt_on;
    logic tdqs_on;
    logic [2:0] rtt_sel;
  } sdpdt_term_t;

endpackage : sdpdt_pkg

// [rtl/sdpdt_ctrl.sv]
// Power-down state tracking and on-die termination control of a DDR3 device.
// Assumes CKE, ODT pins and the decoded command come from the controller.

module sdpdt_ctrl
  import sdpdt_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CKE_IN,
  input wire logic ODT_IN,
  input wire logic [3:0] CMD_IN,
  input wire logic SREF_IN,
  input wire logic BANKS_OPEN_IN,
  input wire logic DLL_RESET_IN,
  input wire sdpdt_cfg_t CFG_IN,
  output logic TERM_ON_OUT,
  output logic TDQS_TERM_OUT,
  output logic [2:0] RTT_SEL_OUT,
  output logic PDOWN_OUT,
  output logic DLL_ON_OUT,
  output logic SELF_REF_OUT
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic cke_s1_r, cke_s2_r, odt_s1_r, odt_s2_r;

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      // Clock enable copies reset high, so release cannot mimic an entry.
      cke_s1_r <= 1'b1;
      cke_s2_r <= 1'b1;
      odt_s1_r <= 1'b0;
      odt_s2_r <= 1'b0;
    end
    else
    begin
      cke_s1_r <= CKE_IN;
      cke_s2_r <= cke_s1_r;
      odt_s1_r <= ODT_IN;
      odt_s2_r <= odt_s1_r;
    end
  end

  function automatic logic is_idle_cmd(input logic [3:0] c);
    is_idle_cmd = (c == SDPDT_CMD_NOP) || (c == SDPDT_CMD_DESELECT);
  endfunction : is_idle_cmd

  // ------------------------------------------------------------
  // Power-down state machine
  // ------------------------------------------------------------
  sdpdt_state_t state_r, state_nxt;
  logic dll_on_r, dll_on_nxt;
  logic [7:0] lock_cnt_r, lock_cnt_nxt;
  logic sync_ok;

  always_comb
  begin
    state_nxt = state_r;
    dll_on_nxt = dll_on_r;
    lock_cnt_nxt = lock_cnt_r;
    if (lock_cnt_r != 8'h00)
      lock_cnt_nxt = lock_cnt_r - 8'h01;
    case (state_r)
      SDPDT_ACTIVE:
      begin
        // Self-refresh entry wins, as its cycle may carry an idle command.
        if (!cke_s2_r && SREF_IN)
        begin
          state_nxt = SDPDT_SREF;
          dll_on_nxt = 1'b0;
        end
        else if (!cke_s2_r && is_idle_cmd(CMD_IN))
        begin
          state_nxt = SDPDT_PDOWN;
          if (!BANKS_OPEN_IN && !CFG_IN.mr0[SDPDT_DLL_A12])
            dll_on_nxt = 1'b0;
        end
      end
      SDPDT_PDOWN:
      begin
        if (cke_s2_r && is_idle_cmd(CMD_IN))
        begin
          state_nxt = dll_on_r ? SDPDT_ACTIVE : SDPDT_RELOCK;
          dll_on_nxt = 1'b1;
          lock_cnt_nxt = SDPDT_TXPDLL_CYC;
        end
      end
      SDPDT_SREF:
      begin
        if (cke_s2_r)
        begin
          state_nxt = SDPDT_RELOCK;
          dll_on_nxt = 1'b1;
          lock_cnt_nxt = SDPDT_TXPDLL_CYC;
        end
      end
      SDPDT_RELOCK:
      begin
        // A DLL reset restarts the lock wait after a frequency change.
        if (DLL_RESET_IN)
          lock_cnt_nxt = SDPDT_TXPDLL_CYC;
        else if (lock_cnt_r <= 8'h01)
          state_nxt = SDPDT_ACTIVE;
      end
      default:
        state_nxt = SDPDT_ACTIVE;
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_r <= SDPDT_ACTIVE;
      dll_on_r <= 1'b1;
      lock_cnt_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      dll_on_r <= dll_on_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  assign sync_ok = dll_on_r && (state_r != SDPDT_RELOCK)
    && (state_r != SDPDT_SREF);

  // ------------------------------------------------------------
  // Termination latency pipeline
  // ------------------------------------------------------------
  // Delay is CWL+AL-2; a shift line keeps it exact up to its depth.
  logic [SDPDT_PIPE_D-1:0] odt_pipe_r, odt_pipe_nxt;
  logic [SDPDT_LAT_W-1:0] odt_lat;
  logic odt_late;
  sdpdt_term_t term_r, term_nxt;
  logic rtt_en;

  assign odt_lat = CFG_IN.cwl + CFG_IN.al - SDPDT_ODT_OFFSET;
  assign rtt_en = CFG_IN.mr1[SDPDT_RTT_A2] | CFG_IN.mr1[SDPDT_RTT_A6]
    | CFG_IN.mr1[SDPDT_RTT_A9];

  always_comb
  begin
    odt_pipe_nxt = {odt_pipe_r[SDPDT_PIPE_D-2:0], odt_s2_r};
    odt_late = (odt_lat == '0) ? odt_s2_r : odt_pipe_r[odt_lat - 5'h01];
    term_nxt = term_r;
    term_nxt.rtt_sel = {CFG_IN.mr1[SDPDT_RTT_A9], CFG_IN.mr1[SDPDT_RTT_A6],
      CFG_IN.mr1[SDPDT_RTT_A2]};
    if (state_r == SDPDT_SREF || !sync_ok || !rtt_en)
      term_nxt.odt_on = 1'b0;
    else
      term_nxt.odt_on = odt_late;
    term_nxt.tdqs_on = term_nxt.odt_on & CFG_IN.mr1[SDPDT_TDQS_A11];
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      odt_pipe_r <= '0;
      term_r <= '0;
    end
    else
    begin
      odt_pipe_r <= odt_pipe_nxt;
      term_r <= term_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic pd_r, sr_r;

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      pd_r <= 1'b0;
      sr_r <= 1'b0;
    end
    else
    begin
      pd_r <= (state_nxt == SDPDT_PDOWN);
      sr_r <= (state_nxt == SDPDT_SREF);
    end
  end

  assign TERM_ON_OUT = term_r.odt_on;
  assign TDQS_TERM_OUT = term_r.tdqs_on;
  assign RTT_SEL_OUT = term_r.rtt_sel;
  assign PDOWN_OUT = pd_r;
  assign DLL_ON_OUT = dll_on_r;
  assign SELF_REF_OUT = sr_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_sref_term_off: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_r == SDPDT_SREF) |=> !TERM_ON_OUT)
    else $error("Termination on during self-refresh.");

  chk_rtt_disable: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    !rtt_en |=> !TERM_ON_OUT)
    else $error("Termination on with nominal select off.");

  chk_strobe_term: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    TDQS_TERM_OUT |-> TERM_ON_OUT)
    else $error("Strobe termination without main termination.");

  chk_slow_dll_off: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_r == SDPDT_ACTIVE && !cke_s2_r && is_idle_cmd(CMD_IN)
      && !BANKS_OPEN_IN && !CFG_IN.mr0[SDPDT_DLL_A12]) |=> !dll_on_r)
    else $error("DLL still on in slow precharge power-down.");

  chk_pd_entry: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (state_r == SDPDT_ACTIVE && !cke_s2_r && is_idle_cmd(CMD_IN)
      && !SREF_IN) |=> PDOWN_OUT)
    else $error("Power-down not entered.");

  chk_relock_span: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    $fell(state_r == SDPDT_RELOCK) |-> $past(lock_cnt_r) == 8'h01)
    else $error("Relock left before DLL exit latency.");

  chk_relock_wait: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    $rose(state_r == SDPDT_RELOCK) |-> !sync_ok [*2])
    else $error("Synchronous termination before DLL exit latency.");

  chk_pin_follow: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    (sync_ok && rtt_en && !odt_late) |=> !TERM_ON_OUT)
    else $error("Termination on with pin low.");

  chk_sync_gate: assert property (
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
    TERM_ON_OUT |-> $past(sync_ok))
    else $error("Termination on without locked DLL.");

endmodule : sdpdt_ctrl

// [verif/sdpdt_ctrl_model.sv]
// Controller-side model driving clock enable, termination and command.
// Assumes requests are set by the bench shortly after a rising edge.
module sdpdt_ctrl_model
  import sdpdt_pkg::*;
#(
  parameter int MIN_HOLD = 4
)
(
  input wire logic clk_in,
  input wire logic pd_req_in,
  input wire logic odt_req_in,
  input wire logic [3:0] cmd_req_in,
  output logic cke_out,
  output logic odt_out,
  output logic [3:0] cmd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int hold_cnt = 0;
  logic pd_s, odt_s;
  logic [3:0] cmd_s;
  initial
  begin
    cke_out = 1'b1;
    odt_out = 1'b0;
    cmd_out = SDPDT_CMD_NOP;
  end
  // Requests are sampled on the edge so the bench never races the model.
  always @(posedge clk_in)
  begin
    pd_s = pd_req_in;
    odt_s = odt_req_in;
    cmd_s = cmd_req_in;
    #1;
    hold_cnt = hold_cnt + 1;
    odt_out = odt_s && cke_out && !pd_s;
    if (cke_out == pd_s && hold_cnt >= MIN_HOLD)
    begin
      cke_out = !pd_s;
      hold_cnt = 0;
    end
    cmd_out = cmd_s;
  end
endmodule : sdpdt_ctrl_model

// [verif/testbench.sv]
// Bench for the power-down and termination block with a reference model.
// Assumes the controller model drives the pins; self-refresh forces ODT.
module testbench
  import sdpdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pd_req = 1'b0, odt_req = 1'b0, sref = 1'b0, banks = 1'b0;
  logic dll_rst = 1'b0;
  logic [3:0] cmd_req = SDPDT_CMD_NOP;
  logic cke, odt_m, term, tdqs, pdn, dll, sr;
  logic [3:0] cmd;
  logic [2:0] rtt;
  sdpdt_cfg_t cfg = '0;
  logic [31:0] lfsr = 32'hEF58;
  int mismatches = 0, num_checks = 0, cyc = 0, lat = 6;
  bit chk_en = 0;
  logic exp_t;
  logic odt_q[$];

  always #5 mclk = ~mclk;
  sdpdt_ctrl_model #(.MIN_HOLD(4)) u_ctrl (.clk_in(mclk),
    .pd_req_in(pd_req), .odt_req_in(odt_req), .cmd_req_in(cmd_req),
    .cke_out(cke), .odt_out(odt_m), .cmd_out(cmd));
  sdpdt_ctrl u_dut (.MCLK_IN(mclk), .SYS_RST_IN(rst), .CKE_IN(cke),
    .ODT_IN(odt_m | sref), .CMD_IN(cmd), .SREF_IN(sref),
    .BANKS_OPEN_IN(banks), .DLL_RESET_IN(dll_rst), .CFG_IN(cfg),
    .TERM_ON_OUT(term), .TDQS_TERM_OUT(tdqs), .RTT_SEL_OUT(rtt),
    .PDOWN_OUT(pdn), .DLL_ON_OUT(dll), .SELF_REF_OUT(sr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task automatic wait_out(input string what, ref logic s, input logic v,
    input int lim);
    int n = 0;
    while (s !== v && n < lim)
    begin
      step(1);
      n++;
    end
    check(what, s, v);
  endtask : wait_out

  task automatic hold(input string what, ref logic s, input logic v,
    input int n);
    repeat (n)
    begin
      step(1);
      check(what, s, v);
    end
  endtask : hold

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Reference model of the termination path
  // ----------------------------------------
  // The pin is seen after two sync flops, then CWL plus AL minus one.
  always @(negedge mclk)
  begin
    cyc++;
    odt_q.push_front(odt_m | sref);
    if (odt_q.size() > 40)
      void'(odt_q.pop_back());
    if (chk_en && odt_q.size() > lat)
    begin
      exp_t = odt_q[lat] & (cfg.mr1[SDPDT_RTT_A9] | cfg.mr1[SDPDT_RTT_A6]
        | cfg.mr1[SDPDT_RTT_A2]);
      check("term", term, exp_t);
      check("tdqs", tdqs, exp_t & cfg.mr1[SDPDT_TDQS_A11]);
    end
    if (cyc > 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    cfg.mr0[SDPDT_DLL_A12] = 1'b1;
    cfg.cwl = 5'h05;
    step(5);
    rst = 1'b0;
    step(1);
    check("rst pdown", pdn, 1'b0);
    check("rst dll", dll, 1'b1);
    check("rst sref", sr, 1'b0);
    check("rst term", term, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      void'(rnd());
      cfg.cwl = 5'(5 + lfsr[1:0]);
      cfg.al = 5'(lfsr[4:2]);
      cfg.mr1 = (i == 0) ? 16'h0000 : lfsr[31:16] & 16'h0A44;
      lat = int'(cfg.cwl) + int'(cfg.al) + 1;
      odt_req = 1'b0;
      step(40);
      check("rtt", rtt, {cfg.mr1[9], cfg.mr1[6], cfg.mr1[2]});
      check("tdqs", tdqs, 1'b0);
      chk_en = 1;
      repeat (60)
      begin
        void'(rnd());
        odt_req = lfsr[0];
        step(1);
      end
      odt_req = 1'b0;
      step(20);
      chk_en = 0;
    end
    $display("test termination latency done");
    cfg.mr1 = 16'h0044;
    cfg.cwl = 5'h05;
    cfg.al = 5'h00;
    cmd_req = 4'h1;
    pd_req = 1'b1;
    hold("pd refused", pdn, 1'b0, 10);
    pd_req = 1'b0;
    step(10);
    cmd_req = SDPDT_CMD_NOP;
    pd_req = 1'b1;
    wait_out("pd entry", pdn, 1'b1, 8);
    check("dll fast", dll, 1'b1);
    pd_req = 1'b0;
    wait_out("pd exit", pdn, 1'b0, 10);
    $display("test fast power-down done");
    cfg.mr0[SDPDT_DLL_A12] = 1'b0;
    banks = 1'b1;
    pd_req = 1'b1;
    wait_out("apd entry", pdn, 1'b1, 10);
    hold("apd dll", dll, 1'b1, 5);
    pd_req = 1'b0;
    wait_out("apd exit", pdn, 1'b0, 10);
    banks = 1'b0;
    step(6);
    pd_req = 1'b1;
    wait_out("slow entry", pdn, 1'b1, 10);
    wait_out("dll off", dll, 1'b0, 4);
    odt_req = 1'b1;
    pd_req = 1'b0;
    wait_out("slow exit", pdn, 1'b0, 10);
    hold("relock", term, 1'b0, 10);
    dll_rst = 1'b1;
    step(1);
    dll_rst = 1'b0;
    hold("relock again", term, 1'b0, 20);
    wait_out("term back", term, 1'b1, 40);
    check("dll back", dll, 1'b1);
    $display("test slow exit done");
    cfg.mr0[SDPDT_DLL_A12] = 1'b1;
    sref = 1'b1;
    pd_req = 1'b1;
    wait_out("sref entry", sr, 1'b1, 10);
    wait_out("sref term", term, 1'b0, 20);
    hold("sref ignore", term, 1'b0, 10);
    sref = 1'b0;
    pd_req = 1'b0;
    wait_out("sref exit", sr, 1'b0, 10);
    $display("test self-refresh done");
    report_and_stop();
  end
endmodule : testbench
